//--- hw/sarcc_pkg.sv
package sarcc_pkg;
   localparam int unsigned RES_BITS = 16;
   localparam int unsigned CFG_BITS = 14;
   localparam int unsigned CLK_HZ = 10_000_000;
   // shortest conversion period at the top sample rate
   localparam int unsigned MAX_RATE_SPS = 500_000;
   localparam int unsigned CONV_PERIOD_CYC = CLK_HZ / MAX_RATE_SPS;
   // input configuration field of the configuration word
   localparam int unsigned INCC_MSB = 12;
   localparam int unsigned INCC_LSB = 10;
   localparam logic [2:0] INCC_BIP_COM = 3'h2;
   localparam logic [15:0] UNI_MAX = 16'hFFFF;
   localparam logic [15:0] UNI_MIN = 16'h0000;
   localparam logic [15:0] BIP_MAX = 16'h7FFF;
   localparam logic [15:0] BIP_MIN = 16'h8000;
   localparam logic [15:0] SIGN_FLIP = 16'h8000;
   localparam logic [15:0] MSB_WEIGHT = 16'h8000;
   localparam logic [13:0] CFG_RESET = 14'h3FFF;

   typedef enum logic [1:0] {
      SARCC_ACQ,
      SARCC_HOLD,
      SARCC_CONV,
      SARCC_DONE
   } sarcc_state_t;

   // result handed to the serial side
   typedef struct packed {
      logic [15:0] code;
      logic [13:0] cfg;
      logic bipolar;
   } sarcc_result_t;

   // comparator and range flags from the analog side
   typedef struct packed {
      logic compare_high;
      logic over_range;
      logic under_range;
   } sarcc_analog_t;
endpackage : sarcc_pkg

//--- hw/sarcc_conv_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - rising conversion_start ends acquisition; sample switches open, holding the input.
// - sixteen binary-weighted steps decide the code, most significant bit first.
// - after the search, return to acquisition, latch the code, report not busy.
// - conversion is timed by the core clock, never by the serial clock.
// - unipolar configurations produce straight binary codes.
// - bipolar configurations produce twos complement codes.
// - unipolar 0000..FFFF with midscale 8000; bipolar 8000..7FFF with zero 0000.
// - input above the span saturates to the largest code of the format.
// - a 14-bit configuration word from the host sets the input mode.
// - result may be read after or during the next conversion, config optionally appended.
// - the published result belongs to the conversion just finished, no latency.
// - rates up to 500 kSPS; converter powered down between conversions.
// - config bits 12..10 pick unipolar or bipolar input modes.
// - the sampling instant is a fixed short delay after the start edge.
module sarcc_conv_ctrl
   import sarcc_pkg::*;
#(
   parameter int unsigned HOLD_CYC = 1,
   parameter int unsigned WIDTH = RES_BITS
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // conversion start pin, asynchronous
   input wire logic conversion_start,
   // configuration word from the serial side
   input wire logic [13:0] cfg_word,
   input wire logic cfg_load,
   // analog front end
   input wire sarcc_analog_t analog,
   output logic positive_sample_switch,
   output logic negative_sample_switch,
   output logic [15:0] dac_trial,
   output logic converter_power_up,
   // result to the serial side
   output sarcc_result_t result,
   output logic result_valid,
   output logic busy
);
   // refuse widths and hold lengths that the counters cannot serve
   if (WIDTH != RES_BITS || HOLD_CYC < 1 || HOLD_CYC > 15)
   begin : g_param_check
      $error("sarcc_conv_ctrl: unsupported parameters");
   end

   logic start_s1_q, start_s2_q, start_s3_q;
   sarcc_state_t state_q, state_d;
   logic [3:0] hold_cnt_q, hold_cnt_d;
   logic [3:0] bit_idx_q, bit_idx_d;
   logic [15:0] sar_q, sar_d;
   logic [13:0] cfg_q, cfg_d;
   logic cfg_active_bip_q, cfg_active_bip_d;
   logic over_q, over_d, under_q, under_d;
   sarcc_result_t result_q, result_d;
   logic valid_q, valid_d;
   // registered drives of the ladder and the sample switches
   logic [15:0] dac_trial_q;
   logic acquiring_q;
   wire [15:0] bit_weight;
   wire [15:0] next_weight;

   // synchroniser, edge found on second and third stage
   // first stage may go metastable; only the second stage reads it
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         start_s1_q <= 1'b0;
      else
         start_s1_q <= conversion_start;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         start_s2_q <= 1'b0;
      else
         start_s2_q <= start_s1_q;
   end

   // delayed copy for the rising-edge detect; resets to the idle pin level
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         start_s3_q <= 1'b0;
      else
         start_s3_q <= start_s2_q;
   end

   wire start_rise = start_s2_q & ~start_s3_q;
   wire [2:0] incc = cfg_q[INCC_MSB:INCC_LSB];
   // 010, 000, 001 bipolar; 1xx unipolar; 011 treated as bipolar pair-like
   wire cfg_bipolar = ~incc[2];
   // one-hot step weights, most significant bit on the first step
   for (genvar b = 0; b < RES_BITS; b++)
   begin : g_weight
      assign bit_weight[b] = (bit_idx_q == 4'(RES_BITS - 1 - b));
      assign next_weight[b] = (bit_idx_d == 4'(RES_BITS - 1 - b));
   end
   wire [15:0] trial = sar_q | bit_weight;
   wire last_bit = (bit_idx_q == 4'(RES_BITS - 1));
   // straight binary magnitude, flipped to twos complement for bipolar
   wire [15:0] raw_code = cfg_active_bip_q ? (sar_q ^ SIGN_FLIP) : sar_q;
   wire [15:0] max_code = cfg_active_bip_q ? BIP_MAX : UNI_MAX;
   wire [15:0] min_code = cfg_active_bip_q ? BIP_MIN : UNI_MIN;
   // over range wins when both range flags are set
   wire saturate = over_q | under_q;
   wire [15:0] sat_code = over_q ? max_code : min_code;
   wire [15:0] final_code = saturate ? sat_code : raw_code;
   // a new word may be loaded in any state; the coding mode is latched at the start edge
   assign cfg_d = cfg_load ? cfg_word : cfg_q;

   // sequencing: acquire, hold, search, publish
   always_comb
   begin
      state_d = state_q;
      hold_cnt_d = hold_cnt_q;
      bit_idx_d = bit_idx_q;
      sar_d = sar_q;
      cfg_active_bip_d = cfg_active_bip_q;
      over_d = over_q;
      under_d = under_q;
      result_d = result_q;
      valid_d = valid_q;
      case (state_q)
         SARCC_ACQ:
         begin
            if (start_rise)
            begin
               state_d = SARCC_HOLD;
               hold_cnt_d = 4'(HOLD_CYC - 1);
               cfg_active_bip_d = cfg_bipolar;
               over_d = 1'b0;
               under_d = 1'b0;
            end
         end
         SARCC_HOLD:
         begin
            if (hold_cnt_q == 4'h0)
            begin
               state_d = SARCC_CONV;
               bit_idx_d = 4'h0;
               sar_d = 16'h0000;
               // range flags sampled at the hold instant
               over_d = analog.over_range;
               under_d = analog.under_range;
            end
            else
               hold_cnt_d = hold_cnt_q - 4'h1;
         end
         SARCC_CONV:
         begin
            // keep the trial bit when the held input still exceeds it
            if (analog.compare_high)
               sar_d = trial;
            if (last_bit)
               state_d = SARCC_DONE;
            else
               bit_idx_d = bit_idx_q + 4'h1;
         end
         SARCC_DONE:
         begin
            // result of this conversion published now, no pipeline
            result_d.code = final_code;
            result_d.cfg = cfg_q;
            result_d.bipolar = cfg_active_bip_q;
            valid_d = 1'b1;
            state_d = SARCC_ACQ;
         end
         default:
            state_d = SARCC_ACQ;
      endcase
   end

   // trial code and acquire flag come from the next state, so the
   // switch and ladder drives never glitch between steps
   wire [15:0] dac_trial_d = (state_d == SARCC_CONV) ? (sar_d | next_weight) : 16'h0000;
   wire acquiring_d = (state_d == SARCC_ACQ);

   // sequencer state
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_q <= SARCC_ACQ;
      else
         state_q <= state_d;
   end

   // countdown from the start edge to the first search step
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         hold_cnt_q <= 4'h0;
      else
         hold_cnt_q <= hold_cnt_d;
   end

   // search step, 0 tests the most significant bit
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         bit_idx_q <= 4'h0;
      else
         bit_idx_q <= bit_idx_d;
   end

   // approximation register, kept bits only
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         sar_q <= 16'h0000;
      else
         sar_q <= sar_d;
   end

   // configuration word, reloadable at any time
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         cfg_q <= CFG_RESET;
      else
         cfg_q <= cfg_d;
   end

   // coding mode frozen for the conversion in flight
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         cfg_active_bip_q <= 1'b0;
      else
         cfg_active_bip_q <= cfg_active_bip_d;
   end

   // above-range flag, captured once at the hold instant
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         over_q <= 1'b0;
      else
         over_q <= over_d;
   end

   // below-range flag, same capture point
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         under_q <= 1'b0;
      else
         under_q <= under_d;
   end

   // published result stands until the next conversion ends
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         result_q <= '0;
      else
         result_q <= result_d;
   end

   // stays set once the first result is out
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         valid_q <= 1'b0;
      else
         valid_q <= valid_d;
   end

   // trial code for the ladder, zero outside the search
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         dac_trial_q <= 16'h0000;
      else
         dac_trial_q <= dac_trial_d;
   end

   // acquire flag, high in reset so the switches start closed
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         acquiring_q <= 1'b1;
      else
         acquiring_q <= acquiring_d;
   end

   // switches closed (high) only while acquiring
   assign positive_sample_switch = acquiring_q;
   assign negative_sample_switch = acquiring_q;
   assign dac_trial = dac_trial_q;
   // powered for hold, search and publish
   // busy and power follow the registered acquire flag
   assign converter_power_up = ~acquiring_q;
   assign busy = ~acquiring_q;
   assign result = result_q;
   assign result_valid = valid_q;
endmodule : sarcc_conv_ctrl
`default_nettype wire

//--- testbench/sarcc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module sarcc_afe_model
   import sarcc_pkg::*;
(
   // front end
   input wire logic core_clk,
   input wire logic positive_sample_switch,
   input wire logic [15:0] dac_trial,
   // bit 17 over range, bit 16 under range, 15..0 input level
   input wire logic [17:0] level,
   output sarcc_analog_t analog
);
   logic [17:0] held_q;
   // tracks while the switch is closed, frozen once it opens
   always_ff @(posedge core_clk)
      if (positive_sample_switch)
         held_q <= level;
   assign analog = {held_q[15:0] >= dac_trial, held_q[17:16]};
endmodule : sarcc_afe_model
`default_nettype wire

//--- testbench/sarcc_conv_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sarcc_chk
   import sarcc_pkg::*;
(
   // watched ports
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic conversion_start,
   input wire logic positive_sample_switch,
   input wire logic negative_sample_switch,
   input wire logic converter_power_up,
   input wire logic [15:0] dac_trial,
   input wire sarcc_result_t result,
   input wire logic result_valid,
   input wire logic busy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_go; $rose(busy); endsequence
   sequence s_run; ##17 busy ##1 !busy; endsequence
   AST_LEN: assert property (s_go |-> s_run) else $error("bad conversion length");
   AST_HOLD: assert property (busy |-> !positive_sample_switch && !negative_sample_switch)
      else $error("switch closed while busy");
   AST_ACQ: assert property (!busy |-> positive_sample_switch && negative_sample_switch && dac_trial == 16'h0000)
      else $error("not acquiring while idle");
   AST_PWR: assert property (converter_power_up == busy) else $error("power state wrong");
   AST_MSB: assert property (s_go |=> dac_trial == 16'h8000 ##1 dac_trial[14:0] == 15'h4000)
      else $error("trial order wrong");
   AST_VALID: assert property ($fell(busy) |-> result_valid) else $error("result not valid");
   AST_KEEP: assert property (!$fell(busy) |-> $stable(result)) else $error("result moved");
   AST_START: assert property ($rose(conversion_start) && !busy |-> ##[1:4] $rose(busy))
      else $error("start not taken");
endmodule : sarcc_chk
bind sarcc_conv_ctrl sarcc_chk sarcc_chk_i (.*);
`default_nettype wire

//--- testbench/sarcc_conv_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sarcc_conv_ctrl_tb;
   import sarcc_pkg::*;
   logic core_clk = 0, rst_n = 0, conversion_start = 0, cfg_load = 0;
   logic [13:0] cfg_word = 14'h3FFF;
   logic [17:0] level = 18'h0_0000;
   logic positive_sample_switch, negative_sample_switch, converter_power_up, result_valid, busy;
   logic [15:0] dac_trial;
   sarcc_analog_t analog;
   sarcc_result_t result;
   int num_errors = 0, check_count = 0;
   logic [2:0] md [10] = '{3'h7, 3'h2, 3'h6, 3'h0, 3'h5, 3'h1, 3'h7, 3'h2, 3'h4, 3'h3};
   logic [17:0] lv [10] = '{18'h0_1234, 18'h0_1234, 18'h0_8000, 18'h0_8000, 18'h0_FFFF,
      18'h0_0000, 18'h2_0005, 18'h2_0005, 18'h1_FFF0, 18'h1_FFF0};
   logic [15:0] ex [10] = '{16'h1234, 16'h9234, 16'h8000, 16'h0000, 16'hFFFF,
      16'h8000, 16'hFFFF, 16'h7FFF, 16'h0000, 16'h8000};
   sarcc_conv_ctrl sarcc_conv_ctrl_i (.core_clk, .rst_n, .conversion_start, .cfg_word, .cfg_load, .analog,
      .positive_sample_switch, .negative_sample_switch, .dac_trial, .converter_power_up, .result,
      .result_valid, .busy);
   sarcc_afe_model sarcc_afe_model_i (.core_clk, .positive_sample_switch, .dac_trial, .level, .analog);
   initial
      forever #50 core_clk = ~core_clk;
   task automatic step();
      @(posedge core_clk);
      #10;
   endtask : step
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input logic [30:0] seen, input logic [30:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 60)
      begin
         step();
         n++;
      end
      if (busy !== lvl)
      begin
         num_errors++;
         final_report();
      end
   endtask : wait_busy
   // one conversion; the level moves and start re-rises while busy
   task automatic conv(input logic [2:0] m, input logic [17:0] v);
      cfg_word = {1'b0, m, 10'h2A5};
      cfg_load = 1;
      step();
      cfg_load = 0;
      level = v;
      conversion_start = 1;
      wait_busy(1);
      level = ~v;
      conversion_start = 0;
      step();
      conversion_start = 1;
      wait_busy(0);
      conversion_start = 0;
   endtask : conv
   initial
   begin
      repeat (16) step();
      chk({busy, result_valid, positive_sample_switch, negative_sample_switch, converter_power_up}, 5'h06);
      chk(result, 31'h0000_0000);
      $display("test reset done");
      rst_n = 1;
      step();
      for (int i = 0; i < 10; i++)
      begin
         conv(md[i], lv[i]);
         chk(result.code, ex[i]);
         chk(result.cfg, cfg_word);
         chk(result.bipolar, !md[i][2]);
         chk(result_valid, 1'b1);
         $display("test %0d done", i);
      end
      repeat (3) step();
      chk(busy, 1'b0);
      $display("test ignored start done");
      conversion_start = 1;
      wait_busy(1);
      rst_n = 0;
      conversion_start = 0;
      #10;
      chk({busy, result_valid}, 2'h0);
      chk(result, 31'h0000_0000);
      step();
      rst_n = 1;
      step();
      step();
      chk({busy, positive_sample_switch}, 2'h1);
      conv(3'h7, 18'h0_4321);
      chk(result.code, 16'h4321);
      chk(result_valid, 1'b1);
      $display("test mid reset done");
      final_report();
   end
endmodule : sarcc_conv_ctrl_tb
`default_nettype wire
